/* File: design/act_pkg.sv */
package act_pkg;

	// register map
	localparam logic [3:0]  TIMING_CTRL_OFS  = 4'h0;
	localparam logic [3:0]  TRIGGER_CFG_OFS  = 4'h4;
	localparam logic [3:0]  SEQ_STATUS_OFS   = 4'h8;
	localparam logic [31:0] TIMING_CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] TIMING_CTRL_MASK = 32'h0000_9fff;
	localparam logic [2:0]  TRIGGER_RST      = 3'h0;

	// field positions
	localparam int SRC_SEL_BIT  = 15;
	localparam int SAMPLE_MSB   = 12;
	localparam int SAMPLE_LSB   = 8;
	localparam int DIVIDER_MSB  = 7;
	localparam int DIVIDER_LSB  = 0;

	// trigger encoding for automatic sampling
	localparam logic [2:0]  TRIGGER_AUTO     = 3'h7;

	// cycles of bus read latency
	localparam logic [0:0]  READ_WAIT_CYCLES = 1'h1;

	typedef enum logic [1:0] {
		ACT_IDLE,
		ACT_SAMPLE,
		ACT_DONE
	} act_seq_e;

endpackage : act_pkg

/* File: design/act_tad_if.sv */
`timescale 1ns/1ps
interface act_tad_if;
	logic       src_sel;
	logic [7:0] divider;
	logic       fast_rc_clk;
	logic       tad_tick;
	logic       tad_level;

	modport gen (
		input  src_sel,
		input  divider,
		input  fast_rc_clk,
		output tad_tick,
		output tad_level
	);
	modport user (
		output src_sel,
		output divider,
		output fast_rc_clk,
		input  tad_tick,
		input  tad_level
	);
endinterface : act_tad_if

/* File: design/act_tad_gen.sv */
`timescale 1ns/1ps
module act_tad_gen (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// tad link
	act_tad_if.gen    tad
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       lvl_q;
	logic       lvl_d;
	logic       tick_q;
	logic       tick_d;
	logic       rc_meta_q;
	logic       rc_sync_q;
	logic       rc_prev_q;

	// fast rc oscillator edge, two-flop synchronised
	always_ff @(posedge clock) begin
		if (rst) begin
			rc_meta_q <= 1'b0;
			rc_sync_q <= 1'b0;
			rc_prev_q <= 1'b0;
		end else begin
			rc_meta_q <= tad.fast_rc_clk;
			rc_sync_q <= rc_meta_q;
			rc_prev_q <= rc_sync_q;
		end
	end

	always_comb begin
		cnt_d  = cnt_q;
		lvl_d  = lvl_q;
		tick_d = 1'b0;
		if (tad.src_sel) begin
			cnt_d = 8'h00;
			if (rc_sync_q && !rc_prev_q) begin
				tick_d = 1'b1;
			end
			lvl_d = rc_sync_q;
		end else if (cnt_q >= tad.divider) begin
			cnt_d  = 8'h00;
			lvl_d  = !lvl_q;
			tick_d = lvl_q;
		end else begin
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q  <= 8'h00;
			lvl_q  <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			lvl_q  <= lvl_d;
			tick_q <= tick_d;
		end
	end

	assign tad.tad_tick  = tick_q;
	assign tad.tad_level = lvl_q;

	// one period from peripheral clock is 2*(div+1) cycles
	// armed only from a tick that fell under a settled source and divider
	int unsigned gap_q;
	logic        gap_ok_q;
	logic [7:0]  div_seen_q;
	logic        src_seen_q;
	always_ff @(posedge clock) begin
		div_seen_q <= tad.divider;
		src_seen_q <= tad.src_sel;
		if (rst || tick_q) begin
			gap_q <= 0;
		end else begin
			gap_q <= gap_q + 1;
		end
		if (rst || tad.src_sel || src_seen_q
			|| tad.divider != div_seen_q) begin
			gap_ok_q <= 1'b0;
		end else if (tick_q) begin
			gap_ok_q <= 1'b1;
		end
	end

	tad_period_a : assert property (@(posedge clock) disable iff (rst)
		!tad.src_sel && $stable(tad.divider) && tick_q && gap_ok_q
		|-> gap_q + 1 == 2 * (int'(tad.divider) + 1))
		else $error("conversion clock period wrong");

	count_bound_a : assert property (@(posedge clock) disable iff (rst)
		!tad.src_sel && $stable(tad.divider) |-> cnt_q <= tad.divider)
		else $error("divider counter overran field");

	rc_ignores_div_a : assert property (@(posedge clock) disable iff (rst)
		tad.src_sel ##1 tad.src_sel |-> cnt_q == 8'h00)
		else $error("divider used while rc selected");

	rc_tick_a : assert property (@(posedge clock) disable iff (rst)
		tad.src_sel && $past(tad.src_sel) && rc_sync_q && !rc_prev_q
		|=> tick_q)
		else $error("rc edge did not tick");

endmodule : act_tad_gen

/* File: design/act_timing_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - Bit 15 picks the conversion clock: 1 fast rc oscillator, 0 bus clock.
// - Bits 12..8 hold the sample time, N conversion clock periods up to 31.
// - Period is peripheral clock period times 2 times (divider plus one).
// - Sample time applies only when the trigger source is 111.
// - Divider is ignored while the fast rc oscillator is selected.
// - Bits 31..16 and 14..13 read zero and ignore writes.
module act_timing_ctrl (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// converter sequencer
	input  wire logic        fast_rc_clk,
	input  wire logic        sample_start,
	output logic             conv_clock,
	output logic             conv_tick,
	output logic             sample_active,
	output logic             sample_done
);
	act_tad_if tad ();

	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [2:0]  trig_q;
	logic [2:0]  trig_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        wait_q;
	logic        wait_d;
	act_pkg::act_seq_e st_q;
	act_pkg::act_seq_e st_d;
	logic [4:0]  scnt_q;
	logic [4:0]  scnt_d;
	logic        done_q;
	logic        done_d;
	logic        act_q;
	logic        act_d;
	logic        clk_q;
	logic        tick_q;
	logic        start_meta_q;
	logic        start_sync_q;
	logic        start_prev_q;

	function automatic logic [31:0] merge_be(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_be

	assign tad.src_sel     = ctrl_q[act_pkg::SRC_SEL_BIT];
	assign tad.divider     = ctrl_q[act_pkg::DIVIDER_MSB:act_pkg::DIVIDER_LSB];
	assign tad.fast_rc_clk = fast_rc_clk;

	act_tad_gen u_gen (
		.clock (clock),
		.rst   (rst),
		.tad   (tad.gen)
	);

	// bus slave: one wait cycle per access, write lands on the answer edge
	always_comb begin
		ctrl_d  = ctrl_q;
		trig_d  = trig_q;
		rdata_d = rdata_q;
		wait_d  = 1'b1;
		if ((avs_read || avs_write) && wait_q) begin
			wait_d = 1'b0;
			if (avs_read) begin
				case (avs_address)
				act_pkg::TIMING_CTRL_OFS: rdata_d = ctrl_q;
				act_pkg::TRIGGER_CFG_OFS: rdata_d = {29'h0, trig_q};
				act_pkg::SEQ_STATUS_OFS: begin
					rdata_d = {24'h0, done_q, act_q, 1'b0, scnt_q};
				end
				default: rdata_d = 32'h0000_0000;
				endcase
			end
		end else if (avs_write) begin
			case (avs_address)
			act_pkg::TIMING_CTRL_OFS: begin
				ctrl_d = merge_be(ctrl_q, avs_writedata, avs_byteenable)
					& act_pkg::TIMING_CTRL_MASK;
			end
			act_pkg::TRIGGER_CFG_OFS: begin
				if (avs_byteenable[0]) begin
					trig_d = avs_writedata[2:0];
				end
			end
			default: begin
			end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q  <= act_pkg::TIMING_CTRL_RST;
			trig_q  <= act_pkg::TRIGGER_RST;
			rdata_q <= 32'h0000_0000;
			wait_q  <= 1'b1;
		end else begin
			ctrl_q  <= ctrl_d;
			trig_q  <= trig_d;
			rdata_q <= rdata_d;
			wait_q  <= wait_d;
		end
	end

	// high while idle, low for the one answer cycle
	assign avs_waitrequest = wait_q;
	assign avs_readdata    = rdata_q;

	// sample start from sequencer, synchronised
	always_ff @(posedge clock) begin
		if (rst) begin
			start_meta_q <= 1'b0;
			start_sync_q <= 1'b0;
			start_prev_q <= 1'b0;
			clk_q        <= 1'b0;
			tick_q       <= 1'b0;
		end else begin
			start_meta_q <= sample_start;
			start_sync_q <= start_meta_q;
			start_prev_q <= start_sync_q;
			clk_q        <= tad.tad_level;
			tick_q       <= tad.tad_tick;
		end
	end

	// sampling interval counted in conversion clock periods
	always_comb begin
		st_d   = st_q;
		scnt_d = scnt_q;
		act_d  = 1'b0;
		done_d = 1'b0;
		case (st_q)
		act_pkg::ACT_IDLE: begin
			if (start_sync_q && !start_prev_q
				&& trig_q == act_pkg::TRIGGER_AUTO) begin
				st_d   = act_pkg::ACT_SAMPLE;
				scnt_d = ctrl_q[act_pkg::SAMPLE_MSB:act_pkg::SAMPLE_LSB];
				act_d  = 1'b1;
			end
		end
		act_pkg::ACT_SAMPLE: begin
			act_d = 1'b1;
			if (tad.tad_tick) begin
				// zero is illegal; treated as one period
				if (scnt_q <= 5'h01) begin
					st_d  = act_pkg::ACT_DONE;
					act_d = 1'b0;
				end else begin
					scnt_d = scnt_q - 5'h01;
				end
			end
		end
		act_pkg::ACT_DONE: begin
			done_d = 1'b1;
			st_d   = act_pkg::ACT_IDLE;
		end
		default: st_d = act_pkg::ACT_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_q   <= act_pkg::ACT_IDLE;
			scnt_q <= 5'h00;
			act_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			scnt_q <= scnt_d;
			act_q  <= act_d;
			done_q <= done_d;
		end
	end

	assign conv_clock    = clk_q;
	assign conv_tick     = tick_q;
	assign sample_active = act_q;
	assign sample_done   = done_q;

	// end of interval: ACT_DONE cycle with done low, one done cycle, then quiet
	sequence done_pulse_seq;
		!done_q ##1 done_q ##1 !done_q;
	endsequence

	reserved_zero_a : assert property (@(posedge clock) disable iff (rst)
		(ctrl_q & ~act_pkg::TIMING_CTRL_MASK) == 32'h0000_0000)
		else $error("reserved control bits set");

	reserved_read_a : assert property (@(posedge clock) disable iff (rst)
		avs_read && !avs_waitrequest
		&& avs_address == act_pkg::TIMING_CTRL_OFS
		|-> (avs_readdata & ~act_pkg::TIMING_CTRL_MASK) == 32'h0000_0000)
		else $error("reserved bits read nonzero");

	write_store_a : assert property (@(posedge clock) disable iff (rst)
		avs_write && !avs_waitrequest
		&& avs_address == act_pkg::TIMING_CTRL_OFS
		&& avs_byteenable == 4'hf
		|=> ctrl_q == ($past(avs_writedata) & act_pkg::TIMING_CTRL_MASK))
		else $error("control write lost");

	manual_ignored_a : assert property (@(posedge clock) disable iff (rst)
		st_q == act_pkg::ACT_IDLE && trig_q != act_pkg::TRIGGER_AUTO
		|=> st_q != act_pkg::ACT_SAMPLE)
		else $error("sampling started without auto trigger");

	sample_load_a : assert property (@(posedge clock) disable iff (rst)
		st_q == act_pkg::ACT_IDLE && st_d == act_pkg::ACT_SAMPLE
		|=> scnt_q == $past(ctrl_q[12:8]))
		else $error("sample count not loaded");

	sample_step_a : assert property (@(posedge clock) disable iff (rst)
		st_q == act_pkg::ACT_SAMPLE && tad.tad_tick && scnt_q > 5'h01
		|=> scnt_q == $past(scnt_q) - 5'h01 && st_q == act_pkg::ACT_SAMPLE)
		else $error("sample count step wrong");

	sample_end_a : assert property (@(posedge clock) disable iff (rst)
		st_q == act_pkg::ACT_SAMPLE && tad.tad_tick && scnt_q <= 5'h01
		|=> done_pulse_seq)
		else $error("sampling end not flagged");

	read_wait_a : assert property (@(posedge clock) disable iff (rst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered in one wait cycle");

endmodule : act_timing_ctrl

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic        clock          = 1'b0;
	logic        rst            = 1'b1;
	logic [3:0]  avs_address    = 4'h0;
	logic        avs_read       = 1'b0;
	logic        avs_write      = 1'b0;
	logic [31:0] avs_writedata  = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        fast_rc_clk    = 1'b0;
	logic        sample_start   = 1'b0;
	logic        conv_clock;
	logic        conv_tick;
	logic        sample_active;
	logic        sample_done;
	int          error_cnt      = 0;
	int          n_tests        = 0;
	int          cyc            = 0;
	int          rc_cnt         = 0;
	int          n;
	int          hi;
	logic [31:0] rd;
	logic [7:0]  dvs [3]        = '{8'h00, 8'h01, 8'hff};

	always #12.5 clock = ~clock;

	act_timing_ctrl dut_u (
		.clock           (clock),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.fast_rc_clk     (fast_rc_clk),
		.sample_start    (sample_start),
		.conv_clock      (conv_clock),
		.conv_tick       (conv_tick),
		.sample_active   (sample_active),
		.sample_done     (sample_done)
	);

	// fast oscillator stand-in, period of ten bus cycles
	always @(posedge clock) begin
		rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
		if (rc_cnt == 4)
			fast_rc_clk <= ~fast_rc_clk;
	end

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt = error_cnt + 1;
			give_verdict();
		end
	end

	task give_verdict;
		if (error_cnt == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	// avalon cycle; waitrequest and readdata taken at the rising edge
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	// skips ticks still in flight from the old setting
	task tick_period(output int p, output int h);
		repeat (3) @(negedge clock);
		do @(negedge clock); while (conv_tick !== 1'b1);
		p = 0;
		h = 0;
		do begin
			@(negedge clock);
			p++;
			if (conv_clock === 1'b1)
				h++;
		end while (conv_tick !== 1'b1);
	endtask : tick_period

	// one sampling request; counts ticks while active and done pulses
	task sample_run(input int nexp, input int dexp);
		int k;
		int t;
		int dn;
		@(posedge clock);
		sample_start <= 1'b1;
		k = 0;
		t = 0;
		dn = 0;
		do begin
			@(negedge clock);
			k++;
		end while (sample_active !== 1'b1 && k < 10);
		// conv_tick trails the internal tick by one cycle
		while (sample_active === 1'b1) begin
			@(negedge clock);
			if (conv_tick === 1'b1)
				t++;
		end
		repeat (3) begin
			if (sample_done === 1'b1)
				dn++;
			@(negedge clock);
		end
		chk(32'(t), 32'(nexp));
		chk(32'(dn), 32'(dexp));
		@(posedge clock);
		sample_start <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : sample_run

	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		bus(1'b0, 4'h0, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		bus(1'b1, 4'h0, 32'hffff_ffff, rd);
		bus(1'b0, 4'h0, 32'h0000_0000, rd);
		chk(rd, 32'h0000_9fff);
		bus(1'b0, 4'hc, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		// bus clock source, divider boundaries
		foreach (dvs[i]) begin
			bus(1'b1, 4'h0, {16'h0000, 8'h01, dvs[i]}, rd);
			tick_period(n, hi);
			chk(32'(n), 32'(2 * (dvs[i] + 1)));
			chk(32'(hi), 32'(dvs[i] + 1));
		end
		// fast oscillator source, divider has no say
		foreach (dvs[i]) begin
			bus(1'b1, 4'h0, {16'h0000, 8'h81, dvs[i]}, rd);
			tick_period(n, hi);
			chk(32'(n), 32'h0000_000a);
			chk(32'(hi), 32'h0000_0005);
		end
		bus(1'b1, 4'h4, 32'h0000_0007, rd);
		bus(1'b0, 4'h4, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0007);
		bus(1'b1, 4'h0, {16'h0000, 8'h01, 8'h01}, rd);
		sample_run(1, 1);
		bus(1'b1, 4'h0, {16'h0000, 8'h1f, 8'h00}, rd);
		sample_run(31, 1);
		// every non-automatic trigger leaves sampling idle
		for (int tr = 0; tr < 7; tr++) begin
			bus(1'b1, 4'h4, 32'(tr), rd);
			sample_run(0, 0);
		end
		give_verdict();
	end
endmodule : testbench
